// ---- hdl/mracc_core.sv ----
// Metering result accumulator: level-9 output scaling and billing banks
// Functional notes
// - Level-9 result grows by source change times a over b.
// - Four level-9 records, one per output result, five fields each.
// - Correction type 0 applies the scaled change with no range handling.
// - Type 1 accepts positive changes only, range 0..2^31, wraps to zero.
// - Correction factors a and b are signed bytes.
// - Source level 0, 1 or 2 picks the measuring level.
// - Source index byte picks the result within that level.
// - Result rises with its source and falls per emitted impulse.
// - Billing results sit in sixteen banks of eight.
// - Each bank record holds seventeen unsigned bytes.
// - Kind 0 none, 1 period value, 2 power as value*3600/period length.
// - Renewal period 0 never, 1..3 at end of measuring period 1..3.
// - Renewal 0 none, 1 write, 2 add, 3 max write, 4 max add.
// - Billing end source 0 never, 1 time alarm, 2 input port impulse.
// - Billing end index picks the alarm or input port.
// - Billing end: 0 none, 1 copy, 2 add, 3/4 same then clear.
// - Renewal only while the bank's tariff, program or port, is active; tariff type 0 is never gated.
// - One connection level per bank, eight connection indexes per bank.
`timescale 1ns/1ns

module mracc_core #(
    parameter int CH      = mracc_pkg::MRACC_L9_CH,
    parameter int NBANK   = mracc_pkg::MRACC_NBANK,
    parameter int NRES    = mracc_pkg::MRACC_NRES,
    parameter int NALARM  = mracc_pkg::MRACC_NALARM,
    parameter int NPORT   = mracc_pkg::MRACC_NPORT,
    parameter int NTARIFF = mracc_pkg::MRACC_NTARIFF
) (
    input  wire logic                                     clk_in,
    input  wire logic                                     nrst_in,
    input  wire mracc_pkg::mracc_out_param_t  [CH-1:0]    output_scaling_params_in,
    input  wire mracc_pkg::mracc_bank_param_t [NBANK-1:0] billing_bank_params_in,
    input  wire logic                                     sample_in,
    input  wire logic [NRES-1:0][31:0]                    level0_result_in,
    input  wire logic [NRES-1:0][31:0]                    level1_result_in,
    input  wire logic [NRES-1:0][31:0]                    level2_result_in,
    input  wire logic [2:0][1:0][NRES-1:0][31:0]          period_value_in,
    input  wire logic [2:0]                               period_end_in,
    input  wire logic [2:0][31:0]                         measuring_period_length_in,
    input  wire logic [NALARM-1:0]                        alarm_in,
    input  wire logic [NPORT-1:0]                         port_pulse_in,
    input  wire logic [NPORT-1:0]                         port_level_in,
    input  wire logic [NTARIFF-1:0]                       tariff_active_in,
    input  wire logic [CH-1:0]                            pulse_slot_in,
    output logic      [CH-1:0]                            pulse_out,
    output logic      [CH-1:0][31:0]                      level9_result_out,
    output logic      [NBANK-1:0][7:0][31:0]              billing_value_out,
    output logic      [NBANK-1:0][7:0][31:0]              last_billing_value_out
);
    import mracc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CH-1:0][31:0]        l9_res;
        logic [CH-1:0][31:0]        l9_prev;
        logic [CH-1:0]              l9_primed;
        logic [CH-1:0]              pulse;
        logic [NBANK-1:0][7:0][31:0] bill;
        logic [NBANK-1:0][7:0][31:0] last_bill;
    } mracc_state_t;

    mracc_state_t st_q;
    mracc_state_t st_d;

    // Result picker; an index past the table reads as zero
    function automatic logic [31:0] mracc_pick(input logic [NRES-1:0][31:0] tab,
                                               input logic [7:0]            idx);
        logic [31:0] val;
        val = '0;
        for (int i = 0; i < NRES; i++)
        begin
            if (8'(i) == idx)
                val = tab[i];
        end
        return val;
    endfunction : mracc_pick

    // Bit picker for alarm, port and tariff vectors
    // Widened to 256 bits so one picker serves every vector width
    function automatic logic mracc_bit(input logic [255:0] vec,
                                       input logic [7:0]   idx,
                                       input int           len);
        return (int'(idx) < len) ? vec[idx] : 1'b0;
    endfunction : mracc_bit

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    mracc_out_param_t  op_p;
    mracc_bank_param_t bk_p;
    logic [31:0]        src;
    logic signed [32:0] delta;
    logic signed [40:0] prod;
    logic signed [40:0] quo;
    logic signed [41:0] sum;
    logic [31:0]        base;
    logic [31:0]        nxt;
    logic               emit;
    logic               step;
    logic               tariff_ok;
    logic               renew_tick;
    logic [1:0]         pidx;
    logic               end_tick;
    logic [31:0]        pval;
    logic [31:0]        v;
    logic [63:0]        pw;
    logic [31:0]        cur;
    logic [31:0]        last;

    always_comb
    begin
        st_d       = st_q;
        op_p       = '0;
        bk_p       = '0;
        src        = '0;
        delta      = '0;
        prod       = '0;
        quo        = '0;
        sum        = '0;
        base       = '0;
        nxt        = '0;
        emit       = 1'b0;
        step       = 1'b0;
        tariff_ok  = 1'b0;
        renew_tick = 1'b0;
        pidx       = 2'h0;
        end_tick   = 1'b0;
        pval       = '0;
        v          = '0;
        pw         = '0;
        cur        = '0;
        last       = '0;
        st_d.pulse = '0;

        for (int c = 0; c < CH; c++)
        begin
            op_p = output_scaling_params_in[c];
            // Unknown level codes reuse the reference: zero change
            // Source level select
            case (op_p.source_level)
                MRACC_LEVEL_0: src = mracc_pick(level0_result_in, op_p.source_index);
                MRACC_LEVEL_1: src = mracc_pick(level1_result_in, op_p.source_index);
                MRACC_LEVEL_2: src = mracc_pick(level2_result_in, op_p.source_index);
                default:       src = st_q.l9_prev[c];
            endcase
            if (op_p.corr_type == MRACC_POSITIVE_WRAP_COUNTER)
                emit = pulse_slot_in[c] && (st_q.l9_res[c] != '0);
            else
                emit = pulse_slot_in[c] && ($signed(st_q.l9_res[c]) > 0);
            // Decrement goes in ahead of this cycle's scaled change
            // Impulse decrements result
            base = st_q.l9_res[c] - {31'h0, emit};
            delta = $signed({1'b0, src}) - $signed({1'b0, st_q.l9_prev[c]});
            prod = delta * op_p.corr_a;
            // Reference still moves with b zero, so a later b starts clean
            // Zero divisor guard
            quo  = (op_p.corr_b == 8'sh00) ? '0 : prod / op_p.corr_b;
            step = sample_in && st_q.l9_primed[c] && (op_p.corr_b != 8'sh00);
            nxt  = base;
            if (step)
            begin
                case (op_p.corr_type)
                    MRACC_CORR_NULL: nxt = base + quo[31:0];
                    MRACC_POSITIVE_WRAP_COUNTER:
                    begin
                        if (quo > 0)
                        begin
                            sum = $signed({10'h000, base}) + quo;
                            sum = 42'(sum % MRACC_WRAP_MOD);
                            nxt = sum[31:0];
                        end
                    end
                    default: nxt = base;
                endcase
            end
            st_d.l9_res[c] = nxt;
            st_d.pulse[c]  = emit;
            // First sample only primes the reference
            if (sample_in)
            begin
                st_d.l9_prev[c]   = src;
                st_d.l9_primed[c] = 1'b1;
            end
        end

        for (int k = 0; k < NBANK; k++)
        begin
            bk_p = billing_bank_params_in[k];
            // Tariff type 0 means no tariff control: tariff_ok always set
            // Tariff gating
            case (bk_p.tariff_type)
                MRACC_TARIFF_NONE: tariff_ok = 1'b1;
                MRACC_TARIFF_PROG:
                    tariff_ok = mracc_bit(256'(tariff_active_in), bk_p.tariff_index, NTARIFF);
                MRACC_TARIFF_PORT:
                    tariff_ok = mracc_bit(256'(port_level_in), bk_p.tariff_index, NPORT);
                default: tariff_ok = 1'b0;
            endcase
            case (bk_p.renewal_period_select)
                MRACC_RENEW_P1: {renew_tick, pidx} = {period_end_in[0], 2'h0};
                MRACC_RENEW_P2: {renew_tick, pidx} = {period_end_in[1], 2'h1};
                MRACC_RENEW_P3: {renew_tick, pidx} = {period_end_in[2], 2'h2};
                default:        {renew_tick, pidx} = {1'b0, 2'h0};
            endcase
            // An index past the vector never ends the period
            // Billing end source
            case (bk_p.billing_end_source)
                MRACC_END_ALARM:
                    end_tick = mracc_bit(256'(alarm_in), bk_p.billing_end_index, NALARM);
                MRACC_END_PORT:
                    end_tick = mracc_bit(256'(port_pulse_in), bk_p.billing_end_index, NPORT);
                default: end_tick = 1'b0;
            endcase
            for (int r = 0; r < MRACC_BANK_RES; r++)
            begin
                cur  = st_q.bill[k][r];
                last = st_q.last_bill[k][r];
                if (bk_p.connection_level == 8'h00)
                    pval = mracc_pick(period_value_in[pidx][0], bk_p.connection_index[r]);
                else
                    pval = mracc_pick(period_value_in[pidx][1], bk_p.connection_index[r]);
                // 64-bit product ahead of the divide: no early overflow
                // Period value or power
                pw = ({32'h0, pval} * {32'h0, MRACC_SEC_PER_HOUR});
                if (measuring_period_length_in[pidx] != '0)
                    pw = pw / {32'h0, measuring_period_length_in[pidx]};
                else
                    pw = '0;
                v = (bk_p.result_kind == MRACC_KIND_POWER) ? pw[31:0] : pval;
                if (renew_tick && tariff_ok && (bk_p.connection_level < 8'h02)
                    && (bk_p.result_kind inside {MRACC_KIND_PERIOD, MRACC_KIND_POWER}))
                begin
                    // Code 0 and codes 5 to 255 fall to default and leave the value alone
                    // Renewal operation
                    case (bk_p.renewal_operation)
                        MRACC_OP_WRITE:    cur = v;
                        MRACC_OP_CUMULATE: cur = cur + v;
                        MRACC_OP_MAX_WR:   cur = (v > cur) ? v : cur;
                        MRACC_OP_MAX_CUM:  cur = (v > cur) ? cur + v : cur;
                        default:           cur = cur;
                    endcase
                end
                if (end_tick)
                begin
                    case (bk_p.billing_end_operation)
                        MRACC_TERM_WRITE:    last = cur;
                        MRACC_TERM_CUMULATE: last = last + cur;
                        MRACC_TERM_WRITE_CLR:
                        begin
                            last = cur;
                            cur  = '0;
                        end
                        MRACC_TERM_CUM_CLR:
                        begin
                            last = last + cur;
                            cur  = '0;
                        end
                        default: last = last;
                    endcase
                end
                st_d.bill[k][r]      = cur;
                st_d.last_bill[k][r] = last;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Whole state clears together; no partial reset paths
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            st_q <= {$bits(mracc_state_t){MRACC_RST_BIT}};
        else
            st_q <= st_d;
    end

    // Outputs straight from flip-flops
    assign pulse_out              = st_q.pulse;
    assign level9_result_out      = st_q.l9_res;
    assign billing_value_out      = st_q.bill;
    assign last_billing_value_out = st_q.last_bill;

endmodule : mracc_core

// ---- hdl/mracc_pkg.sv ----
// Metering result accumulator: constants, codes and record layouts
package mracc_pkg;

    // ------------------------------------------------------------
    // Sizes and constants
    // ------------------------------------------------------------
    localparam int MRACC_W        = 32;
    localparam int MRACC_L9_CH    = 4;
    localparam int MRACC_NBANK    = 16;
    localparam int MRACC_BANK_RES = 8;
    localparam int MRACC_NRES     = 16;
    localparam int MRACC_NALARM   = 8;
    localparam int MRACC_NPORT    = 8;
    localparam int MRACC_NTARIFF  = 8;
    localparam int MRACC_NPERIOD  = 3;
    // Wrap modulus keeps the counter within 0 .. 2^31
    localparam logic [41:0] MRACC_WRAP_MOD     = 42'h000_8000_0001;
    localparam logic [31:0] MRACC_SEC_PER_HOUR = 32'h0000_0e10;
    localparam logic        MRACC_RST_BIT      = 1'b0;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        MRACC_CORR_NULL             = 8'h00,
        MRACC_POSITIVE_WRAP_COUNTER = 8'h01
    } mracc_corr_t;

    typedef enum logic [7:0] {
        MRACC_LEVEL_0 = 8'h00,
        MRACC_LEVEL_1 = 8'h01,
        MRACC_LEVEL_2 = 8'h02
    } mracc_level_t;

    typedef enum logic [7:0] {
        MRACC_KIND_NONE   = 8'h00,
        MRACC_KIND_PERIOD = 8'h01,
        MRACC_KIND_POWER  = 8'h02
    } mracc_kind_t;

    typedef enum logic [7:0] {
        MRACC_RENEW_NEVER = 8'h00,
        MRACC_RENEW_P1    = 8'h01,
        MRACC_RENEW_P2    = 8'h02,
        MRACC_RENEW_P3    = 8'h03
    } mracc_period_t;

    typedef enum logic [7:0] {
        MRACC_OP_NONE     = 8'h00,
        MRACC_OP_WRITE    = 8'h01,
        MRACC_OP_CUMULATE = 8'h02,
        MRACC_OP_MAX_WR   = 8'h03,
        MRACC_OP_MAX_CUM  = 8'h04
    } mracc_renew_t;

    typedef enum logic [7:0] {
        MRACC_END_NEVER = 8'h00,
        MRACC_END_ALARM = 8'h01,
        MRACC_END_PORT  = 8'h02
    } mracc_end_src_t;

    typedef enum logic [7:0] {
        MRACC_TERM_NONE      = 8'h00,
        MRACC_TERM_WRITE     = 8'h01,
        MRACC_TERM_CUMULATE  = 8'h02,
        MRACC_TERM_WRITE_CLR = 8'h03,
        MRACC_TERM_CUM_CLR   = 8'h04
    } mracc_end_op_t;

    typedef enum logic [7:0] {
        MRACC_TARIFF_NONE = 8'h00,
        MRACC_TARIFF_PROG = 8'h01,
        MRACC_TARIFF_PORT = 8'h02
    } mracc_tariff_t;

    // ------------------------------------------------------------
    // Parameter records
    // ------------------------------------------------------------
    typedef struct packed {
        mracc_corr_t        corr_type;
        logic signed [7:0]  corr_a;
        logic signed [7:0]  corr_b;
        mracc_level_t       source_level;
        logic [7:0]         source_index;
    } mracc_out_param_t;

    typedef struct packed {
        mracc_kind_t        result_kind;
        mracc_period_t      renewal_period_select;
        mracc_renew_t       renewal_operation;
        mracc_end_src_t     billing_end_source;
        logic [7:0]         billing_end_index;
        mracc_end_op_t      billing_end_operation;
        mracc_tariff_t      tariff_type;
        logic [7:0]         tariff_index;
        logic [7:0]         connection_level;
        logic [7:0][7:0]    connection_index;
    } mracc_bank_param_t;

endpackage : mracc_pkg

// ---- sim/mracc_core_bench.sv ----
// Self-checking bench for the metering result accumulator
`timescale 1ns/1ns

module mracc_core_bench;
    import mracc_pkg::*;

    logic                       clk_in, nrst_in, sample_in;
    mracc_out_param_t  [3:0]    osp;
    mracc_bank_param_t [15:0]   bbp;
    logic [15:0][31:0]          lv0, lv1, lv2;
    logic [2:0][1:0][15:0][31:0] pv;
    logic [2:0]                 pend;
    logic [2:0][31:0]           mpl;
    logic [7:0]                 alarm, ppulse, plevel, tact;
    logic [3:0]                 grant, slot, pulse;
    logic [3:0][7:0]            cnt;
    logic [3:0][31:0]           l9;
    logic [15:0][7:0][31:0]     bv, last_billing_value;
    int                         n_errors, compares;

    mracc_core dut (.clk_in(clk_in), .nrst_in(nrst_in), .output_scaling_params_in(osp),
        .billing_bank_params_in(bbp), .sample_in(sample_in), .level0_result_in(lv0),
        .level1_result_in(lv1), .level2_result_in(lv2), .period_value_in(pv),
        .period_end_in(pend), .measuring_period_length_in(mpl), .alarm_in(alarm),
        .port_pulse_in(ppulse), .port_level_in(plevel), .tariff_active_in(tact),
        .pulse_slot_in(slot), .pulse_out(pulse), .level9_result_out(l9),
        .billing_value_out(bv), .last_billing_value_out(last_billing_value));
    mracc_pulse_line #(.CH(4)) u_line (.clk_in(clk_in), .nrst_in(nrst_in),
        .grant_in(grant), .pulse_in(pulse), .slot_out(slot), .count_out(cnt));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task conclude;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // One sample cycle, checked after the answering edge
    task smp;
        @(posedge clk_in) sample_in <= 1'b1;
        @(posedge clk_in) sample_in <= 1'b0;
        @(negedge clk_in);
    endtask : smp
    task strobe(input logic [2:0] p, input logic [7:0] a, input logic [7:0] q);
        @(posedge clk_in)
        begin
            pend <= p;
            alarm <= a;
            ppulse <= q;
        end
        @(posedge clk_in)
        begin
            pend <= '0;
            alarm <= '0;
            ppulse <= '0;
        end
        @(negedge clk_in);
    endtask : strobe

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_scale;
        chk("l9 after reset", 32'h0, l9[0] | l9[1] | l9[2] | l9[3]);
        @(posedge clk_in) sample_in <= 1'b1;
        @(posedge clk_in)
        begin
            lv0 <= {16{32'd110}};
            lv1 <= {16{32'd110}};
            lv2 <= {16{32'd110}};
        end
        smp();
        chk("ch0", 32'h0000_000f, l9[0]);
        chk("ch1", 32'h0, l9[1]);
        chk("ch2", 32'h0000_000a, l9[2]);
        chk("ch3", 32'hffff_ffec, l9[3]);
    endtask : t_scale
    task t_emit;
        @(posedge clk_in) grant <= 4'hf;
        repeat (30) @(posedge clk_in);
        grant <= 4'h0;
        repeat (3) @(negedge clk_in);
        chk("pulses ch0", 32'd15, 32'(cnt[0]));
        chk("pulses ch2", 32'd10, 32'(cnt[2]));
        chk("pulses ch3", 32'd0, 32'(cnt[3]));
        chk("ch0 drained", 32'h0, l9[0]);
        chk("ch3 kept", 32'hffff_ffec, l9[3]);
    endtask : t_emit
    task t_wrap;
        @(posedge clk_in) lv2[0] <= 32'h8000_006e;
        smp();
        chk("wrap max", 32'h8000_0000, l9[2]);
        @(posedge clk_in) lv2[0] <= 32'h8000_006f;
        smp();
        chk("wrap over", 32'h0, l9[2]);
        @(posedge clk_in) lv2[0] <= 32'h8000_006a;
        smp();
        chk("wrap negative", 32'h0, l9[2]);
        chk("ch0 idle", 32'h0, l9[0]);
    endtask : t_wrap
    task t_bill;
        strobe(3'b001, 8'h00, 8'h00);
        strobe(3'b011, 8'h00, 8'h00);
        @(posedge clk_in) tact <= 8'h02;
        strobe(3'b010, 8'h00, 8'h00);
        strobe(3'b010, 8'h00, 8'h00);
        strobe(3'b100, 8'h00, 8'h00);
        for (int r = 0; r < 8; r++)
            chk("bank3 gated", 32'h0, bv[3][r]);
        @(posedge clk_in) plevel <= 8'h10;
        strobe(3'b100, 8'h00, 8'h00);
        strobe(3'b100, 8'h00, 8'h00);
        for (int r = 0; r < 8; r++)
        begin
            chk("bank0 sum", 32'(2 * (r + 1)), bv[0][r]);
            chk("bank1 max", 32'(r + 1), bv[1][r]);
            chk("bank2 none", 32'h0, bv[2][r]);
            chk("bank3 write", 32'(r + 1), bv[3][r]);
            chk("bank4 max add", 32'(r + 1), bv[4][r]);
        end
        strobe(3'b000, 8'h04, 8'h0a);
        for (int r = 0; r < 8; r++)
        begin
            chk("bank0 last", 32'(2 * (r + 1)), last_billing_value[0][r]);
            chk("bank0 clear", 32'h0, bv[0][r]);
            chk("bank1 last", 32'(r + 1), last_billing_value[1][r]);
            chk("bank1 kept", 32'(r + 1), bv[1][r]);
            chk("bank3 last", 32'(r + 1), last_billing_value[3][r]);
            chk("bank3 clear", 32'h0, bv[3][r]);
            chk("bank4 last", 32'(r + 1), last_billing_value[4][r]);
            chk("bank4 kept", 32'(r + 1), bv[4][r]);
        end
    endtask : t_bill

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (5000) @(posedge clk_in);
        n_errors++;
        conclude();
    end
    initial
    begin
        n_errors = 0;
        compares = 0;
        nrst_in = 1'b0;
        sample_in = 1'b0;
        osp[0] = '{MRACC_POSITIVE_WRAP_COUNTER, 8'h03, 8'h02, MRACC_LEVEL_0, 8'h05};
        osp[1] = '{MRACC_CORR_NULL, 8'h05, 8'h00, MRACC_LEVEL_1, 8'h02};
        osp[2] = '{MRACC_POSITIVE_WRAP_COUNTER, 8'h01, 8'h01, MRACC_LEVEL_2, 8'h00};
        osp[3] = '{MRACC_CORR_NULL, 8'hfe, 8'h01, MRACC_LEVEL_0, 8'h01};
        bbp = '0;
        bbp[0] = '{MRACC_KIND_PERIOD, MRACC_RENEW_P1, MRACC_OP_CUMULATE, MRACC_END_ALARM,
            8'h02, MRACC_TERM_WRITE_CLR, MRACC_TARIFF_NONE, 8'h00, 8'h00, 64'h0706050403020100};
        bbp[1] = '{MRACC_KIND_POWER, MRACC_RENEW_P2, MRACC_OP_MAX_WR, MRACC_END_PORT,
            8'h03, MRACC_TERM_CUMULATE, MRACC_TARIFF_PROG, 8'h01, 8'h01, 64'h0706050403020100};
        bbp[3] = '{MRACC_KIND_PERIOD, MRACC_RENEW_P3, MRACC_OP_WRITE, MRACC_END_PORT,
            8'h01, MRACC_TERM_CUM_CLR, MRACC_TARIFF_PORT, 8'h04, 8'h00, 64'h0706050403020100};
        bbp[4] = '{MRACC_KIND_PERIOD, MRACC_RENEW_P1, MRACC_OP_MAX_CUM, MRACC_END_ALARM,
            8'h02, MRACC_TERM_WRITE, MRACC_TARIFF_NONE, 8'h00, 8'h01, 64'h0706050403020100};
        lv0 = {16{32'd100}};
        lv1 = {16{32'd100}};
        lv2 = {16{32'd100}};
        for (int n = 0; n < 96; n++)
            pv[n / 32][(n / 16) % 2][n % 16] = 32'(n % 16 + 1);
        mpl = {3{32'h0000_0e10}};
        pend = '0;
        alarm = '0;
        ppulse = '0;
        plevel = '0;
        tact = '0;
        grant = '0;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(negedge clk_in);
        t_scale();
        t_emit();
        t_wrap();
        t_bill();
        conclude();
    end
endmodule : mracc_core_bench

// ---- sim/mracc_core_props.sv ----
// Concurrent checks on the metering result accumulator ports
`timescale 1ns/1ns

module mracc_core_props #(
    parameter int CH     = mracc_pkg::MRACC_L9_CH,
    parameter int NBANK  = mracc_pkg::MRACC_NBANK,
    parameter int NALARM = mracc_pkg::MRACC_NALARM,
    parameter int NPORT  = mracc_pkg::MRACC_NPORT
) (
    input wire logic                                     clk_in,
    input wire logic                                     nrst_in,
    input wire mracc_pkg::mracc_out_param_t  [CH-1:0]    output_scaling_params_in,
    input wire logic                                     sample_in,
    input wire logic [2:0]                               period_end_in,
    input wire logic [NALARM-1:0]                        alarm_in,
    input wire logic [NPORT-1:0]                         port_pulse_in,
    input wire logic [CH-1:0]                            pulse_slot_in,
    input wire logic [CH-1:0]                            pulse_out,
    input wire logic [CH-1:0][31:0]                      level9_result_out,
    input wire logic [NBANK-1:0][7:0][31:0]              billing_value_out,
    input wire logic [NBANK-1:0][7:0][31:0]              last_billing_value_out
);
    import mracc_pkg::*;

    // ------------------------------------------------------------
    // Level-9 emission and scaling
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // Sampling excluded: an increment may land on the same edge
    property p_emit_dec;
        pulse_out[0] && !$past(sample_in)
            |-> level9_result_out[0] == $past(level9_result_out[0]) - 32'h1;
    endproperty
    a_emit_dec: assert property (p_emit_dec) else $error("emit without decrement");
    property p_no_emit_zero;
        $past(pulse_slot_in[0]) && $past(level9_result_out[0]) == 32'h0 |-> !pulse_out[0];
    endproperty
    a_no_emit_zero: assert property (p_no_emit_zero) else $error("emit from zero");
    property p_emit_slot;
        pulse_out[0] |-> $past(pulse_slot_in[0]);
    endproperty
    a_emit_slot: assert property (p_emit_slot) else $error("emit without slot");
    property p_hold;
        !$past(sample_in) && !pulse_out[0] |-> $stable(level9_result_out[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved without cause");
    property p_zero_b;
        $past(output_scaling_params_in[1].corr_b) == 8'h00 && !pulse_out[1]
            |-> $stable(level9_result_out[1]);
    endproperty
    a_zero_b: assert property (p_zero_b) else $error("zero divisor updated");
    property p_wrap_range;
        output_scaling_params_in[2].corr_type == MRACC_POSITIVE_WRAP_COUNTER
            |-> level9_result_out[2] <= 32'h8000_0000;
    endproperty
    a_wrap_range: assert property (p_wrap_range) else $error("wrap counter out of range");

    // ------------------------------------------------------------
    // Billing banks
    // ------------------------------------------------------------
    property p_last_cause;
        $changed(last_billing_value_out) |-> $past(|alarm_in || |port_pulse_in);
    endproperty
    a_last_cause: assert property (p_last_cause) else $error("last value moved");
    property p_bill_cause;
        $changed(billing_value_out)
            |-> $past(|period_end_in || |alarm_in || |port_pulse_in);
    endproperty
    a_bill_cause: assert property (p_bill_cause) else $error("billing value moved");
endmodule : mracc_core_props

bind mracc_core mracc_core_props #(.CH(CH), .NBANK(NBANK), .NALARM(NALARM), .NPORT(NPORT))
    u_props (.clk_in(clk_in), .nrst_in(nrst_in),
        .output_scaling_params_in(output_scaling_params_in), .sample_in(sample_in),
        .period_end_in(period_end_in), .alarm_in(alarm_in), .port_pulse_in(port_pulse_in),
        .pulse_slot_in(pulse_slot_in), .pulse_out(pulse_out),
        .level9_result_out(level9_result_out), .billing_value_out(billing_value_out),
        .last_billing_value_out(last_billing_value_out));

// ---- sim/mracc_pulse_line.sv ----
// Output pulse line model: grants emission slots and tallies impulses
`timescale 1ns/1ns

module mracc_pulse_line #(
    parameter int CH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic [CH-1:0]    grant_in,
    input  wire logic [CH-1:0]    pulse_in,
    output logic      [CH-1:0]    slot_out,
    output logic [CH-1:0][7:0]    count_out
);
    // A stalled line simply withholds its slot
    assign slot_out = grant_in;

    // One impulse per high cycle of each line
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            count_out <= '0;
        else
            for (int c = 0; c < CH; c++)
                count_out[c] <= count_out[c] + 8'(pulse_in[c]);
    end
endmodule : mracc_pulse_line
